// ==== dsr_pkg.sv ====
// Constants, register map and field layout of the diagnostic status reporter.
// Assumes an APB master on the same 25 MHz clock as the block.
package dsr_pkg;

  localparam int unsigned NUM_ENC     = 4;
  localparam int unsigned CAUSE_W     = 4;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_STATUS  = 12'h000;
  localparam logic [11:0] OFS_MASK    = 12'h004;
  localparam logic [11:0] OFS_CTRL    = 12'h008;
  localparam logic [11:0] OFS_LIVE    = 12'h00c;
  localparam logic [11:0] OFS_DIAG    = 12'h010;
  localparam logic [11:0] OFS_ACK     = 12'h014;
  localparam logic [11:0] OFS_SDDELAY = 12'h018;
  localparam logic [11:0] OFS_SDRAMP  = 12'h01c;

  // ---------------------------------------------------------------
  // Status/mask/live bit positions
  // ---------------------------------------------------------------
  localparam int unsigned B_SYNC      = 0;
  localparam int unsigned B_CMD       = 1;
  localparam int unsigned B_TEMP      = 2;
  localparam int unsigned B_DRDY      = 3;
  localparam int unsigned B_WIRE      = 4;  // 4 bits, one per encoder
  localparam int unsigned B_ZMARK     = 8;  // 4 bits, one per encoder
  localparam int unsigned NUM_EV      = 12;

  // Diag block fields
  localparam int unsigned D_VALID     = 31;
  localparam int unsigned D_CLASS     = 24; // 0 internal, 1 external
  localparam int unsigned D_SLOT      = 16; // 8 bits
  localparam int unsigned D_CHAN      = 8;  // 8 bits
  localparam int unsigned D_CAUSE     = 0;  // 4 bits

  // Control register fields
  localparam int unsigned C_BUSOK     = 0;
  localparam int unsigned C_STEPPER   = 1;  // 4 bits, one per encoder

  // Causes, class and slots
  localparam logic [3:0] CAUSE_SYNC   = 4'h1;
  localparam logic [3:0] CAUSE_TEMP   = 4'h2;
  localparam logic [3:0] CAUSE_CMD    = 4'h3;
  localparam logic [3:0] CAUSE_WIRE   = 4'h4;
  localparam logic [3:0] CAUSE_DRDY   = 4'h5;
  localparam logic [3:0] CAUSE_ZMARK  = 4'h6;
  localparam logic       CLASS_INT    = 1'b0;
  localparam logic       CLASS_EXT    = 1'b1;
  localparam logic [7:0] SLOT_MODULE  = 8'h00;
  localparam logic [7:0] SLOT_ENC0    = 8'h04;
  localparam logic [7:0] SLOT_STEP    = 8'h03;
  localparam logic [7:0] CHAN_ALWAYS  = 8'h00;
  localparam logic [4:0] UNSUP_MASK   = 5'h1f; // control word bits 12..8

  // Reset values
  localparam logic [31:0] RST_MASK    = 32'h0000_0000;
  localparam logic [15:0] RST_SDDELAY = 16'h0000;
  localparam logic [15:0] RST_SDRAMP  = 16'h0000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned TICK_US     = 1;
  localparam int unsigned TICK_CYC    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned BLINK_MS    = 250;
  localparam int unsigned BLINK_TICKS = BLINK_MS * 1000 / TICK_US;

  typedef enum logic [1:0] {
    DSR_SD_IDLE  = 2'b00,
    DSR_SD_DELAY = 2'b01,
    DSR_SD_RAMP  = 2'b10,
    DSR_SD_OFF   = 2'b11
  } dsr_sd_t;

endpackage

// ==== dsr_top.sv ====
// Diagnostic status reporter: lamps, fault capture, one-at-a-time diag block.
// Assumes fault inputs come from pins (synchronised here) and an APB master.
`timescale 1ns/100ps

module dsr_top
  import dsr_pkg::*;
#(
  parameter int unsigned ENC_N = NUM_ENC
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 sync_lost,
  input  wire logic                 overtemp,
  input  wire logic                 drive_ready,
  input  wire logic                 ready_contact,
  input  wire logic                 cyclic_exchange,
  input  wire logic [ENC_N*16-1:0]  encoder_control_word,
  input  wire logic [ENC_N-1:0]     enc_wire_break,
  input  wire logic [ENC_N-1:0]     enc_zero_mark_err,
  input  wire logic [ENC_N-1:0]     step_mismatch,
  input  wire logic [ENC_N-1:0]     proximity_switch_signal,
  output logic                      group_fault_lamp,
  output logic                      bus_fault_lamp,
  output logic                      temp_lamp,
  output logic                      ready_lamp,
  output logic                      drive_enable,
  output logic      [15:0]          ramp_level,
  output logic                      irq
);

  // -----------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------
  localparam int unsigned SW = 5 + 3 * ENC_N;
  // Reset to idle pin levels: drive_ready rests high, so a zero here
  // would log a false drive-ready fault right after reset
  localparam logic [SW-1:0] SY_RST = SW'(3'b100);
  logic [SW-1:0] sy1;
  logic [SW-1:0] sy2;
  logic [SW-1:0] raw_in;

  assign raw_in = {step_mismatch, enc_zero_mark_err, enc_wire_break,
                   cyclic_exchange, ready_contact, drive_ready, overtemp,
                   sync_lost};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1 <= SY_RST;
      sy2 <= SY_RST;
    end else begin
      sy1 <= raw_in;
      sy2 <= sy1;
    end
  end

  logic             s_sync;
  logic             s_temp;
  logic             s_drdy;
  logic             s_rdy;
  logic             s_cyc;
  logic [ENC_N-1:0] s_wire;
  logic [ENC_N-1:0] s_zm;
  logic [ENC_N-1:0] s_step;
  assign s_sync = sy2[0];
  assign s_temp = sy2[1];
  assign s_drdy = sy2[2];
  assign s_rdy  = sy2[3];
  assign s_cyc  = sy2[4];
  assign s_wire = sy2[5 +: ENC_N];
  assign s_zm   = sy2[5 + ENC_N +: ENC_N];
  assign s_step = sy2[5 + 2*ENC_N +: ENC_N];

  // Proximity switch and control word arrive from other domains too
  logic [ENC_N-1:0]    px1;
  logic [ENC_N-1:0]    px2;
  logic [ENC_N*16-1:0] cw1;
  logic [ENC_N*16-1:0] cw2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      px1 <= '0;
      px2 <= '0;
      cw1 <= '0;
      cw2 <= '0;
    end else begin
      px1 <= proximity_switch_signal;
      px2 <= px1;
      cw1 <= encoder_control_word;
      cw2 <= cw1;
    end
  end

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  logic [NUM_EV-1:0] status;
  logic [NUM_EV-1:0] mask;
  logic [31:0]       ctrl;
  logic [15:0]       sd_delay;
  logic [15:0]       sd_ramp;
  logic [31:0]       diag;
  logic [NUM_EV-1:0] reported;

  logic wr_en;
  logic rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  function automatic logic is_mapped(input logic [11:0] a);
    return a == OFS_STATUS || a == OFS_MASK || a == OFS_CTRL ||
           a == OFS_LIVE || a == OFS_DIAG || a == OFS_ACK ||
           a == OFS_SDDELAY || a == OFS_SDRAMP;
  endfunction

  // -----------------------------------------------------------------
  // Live fault vector
  // -----------------------------------------------------------------
  logic [ENC_N-1:0]  unsup;
  logic [ENC_N-1:0]  zm_fault;
  logic [NUM_EV-1:0] live;
  logic              stepper_mode [ENC_N];

  for (genvar g = 0; g < ENC_N; g++) begin : g_enc
    assign unsup[g] = |(cw2[g*16+8 +: 5] & UNSUP_MASK);
    assign stepper_mode[g] = ctrl[C_STEPPER + g];
    // Stepper: mismatch only counts while the switch reports a reference
    assign zm_fault[g] = stepper_mode[g] ? (s_step[g] && px2[g])
                                         : s_zm[g];
  end

  always_comb begin
    live           = '0;
    live[B_SYNC]   = s_sync;
    live[B_CMD]    = |unsup;
    live[B_TEMP]   = s_temp;
    live[B_DRDY]   = !s_drdy;
    live[B_WIRE +: 4]  = s_wire[3:0];
    live[B_ZMARK +: 4] = zm_fault[3:0];
  end

  // Sticky status; a new event wins over the read-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else if (rd_en && paddr == OFS_STATUS) begin
      status <= live;
    end else begin
      status <= status | live;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask     <= RST_MASK[NUM_EV-1:0];
      ctrl     <= '0;
      sd_delay <= RST_SDDELAY;
      sd_ramp  <= RST_SDRAMP;
    end else if (wr_en) begin
      case (paddr)
        OFS_MASK:    mask     <= pwdata[NUM_EV-1:0];
        OFS_CTRL:    ctrl     <= pwdata;
        OFS_SDDELAY: sd_delay <= pwdata[15:0];
        OFS_SDRAMP:  sd_ramp  <= pwdata[15:0];
        default:     ;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Diagnostic interrupt block, one outstanding at a time
  // -----------------------------------------------------------------
  function automatic logic [7:0] enc_slot(input int unsigned idx);
    return SLOT_ENC0 + 8'(idx) * SLOT_STEP;
  endfunction

  logic [NUM_EV-1:0] pend;
  logic              ack;
  logic              signalled;
  assign pend = status & ~reported;
  assign ack  = wr_en && paddr == OFS_ACK;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag      <= '0;
      reported  <= '0;
      signalled <= 1'b0;
    end else begin
      // A cause stays reported until a status read finds it gone, so a
      // sticky bit is never reported twice for the same occurrence
      reported <= reported & status;
      if (ack) begin
        diag[D_VALID] <= 1'b0;
      end else if (!diag[D_VALID] && |pend) begin
        signalled     <= 1'b1;
        diag[D_VALID] <= 1'b1;
        diag[D_CHAN +: 8] <= CHAN_ALWAYS;
        if (pend[B_SYNC]) begin
          diag[D_CLASS] <= CLASS_INT;
          diag[D_SLOT +: 8]  <= SLOT_MODULE;
          diag[D_CAUSE +: 4] <= CAUSE_SYNC;
          reported[B_SYNC]   <= 1'b1;
        end else if (pend[B_CMD]) begin
          diag[D_CLASS] <= CLASS_INT;
          diag[D_SLOT +: 8]  <= SLOT_MODULE;
          diag[D_CAUSE +: 4] <= CAUSE_CMD;
          reported[B_CMD]    <= 1'b1;
        end else if (pend[B_TEMP]) begin
          diag[D_CLASS] <= CLASS_INT;
          diag[D_SLOT +: 8]  <= SLOT_MODULE;
          diag[D_CAUSE +: 4] <= CAUSE_TEMP;
          reported[B_TEMP]   <= 1'b1;
        end else if (pend[B_DRDY]) begin
          diag[D_CLASS] <= CLASS_EXT;
          diag[D_SLOT +: 8]  <= SLOT_MODULE;
          diag[D_CAUSE +: 4] <= CAUSE_DRDY;
          reported[B_DRDY]   <= 1'b1;
        end else begin
          for (int i = ENC_N - 1; i >= 0; i--) begin
            if (pend[B_WIRE + i] || pend[B_ZMARK + i]) begin
              diag[D_CLASS]     <= CLASS_EXT;
              diag[D_SLOT +: 8] <= enc_slot(i);
            end
          end
          for (int i = ENC_N - 1; i >= 0; i--) begin
            if (pend[B_WIRE + i]) begin
              diag[D_CAUSE +: 4] <= CAUSE_WIRE;
              reported[B_WIRE + i] <= 1'b1;
            end else if (pend[B_ZMARK + i]) begin
              diag[D_CAUSE +: 4] <= CAUSE_ZMARK;
              reported[B_ZMARK + i] <= 1'b1;
            end
          end
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // Overtemperature shutdown: delay, then ramp down to off
  // -----------------------------------------------------------------
  dsr_sd_t     sd_state;
  logic [4:0]  tick_cnt;
  logic        tick;
  logic [15:0] sd_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick     <= tick_cnt == 5'(TICK_CYC - 1);
      tick_cnt <= (tick_cnt == 5'(TICK_CYC - 1)) ? '0 : tick_cnt + 5'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_state     <= DSR_SD_IDLE;
      sd_cnt       <= '0;
      ramp_level   <= 16'hffff;
      drive_enable <= 1'b1;
    end else begin
      case (sd_state)
        DSR_SD_IDLE: begin
          ramp_level   <= 16'hffff;
          drive_enable <= 1'b1;
          if (s_temp) begin
            sd_state <= DSR_SD_DELAY;
            sd_cnt   <= sd_delay;
          end
        end
        DSR_SD_DELAY: begin
          if (tick) begin
            if (sd_cnt == 16'h0000) begin
              sd_state <= DSR_SD_RAMP;
            end else begin
              sd_cnt <= sd_cnt - 16'd1;
            end
          end
        end
        DSR_SD_RAMP: begin
          // Linear ramp: step size from the ramp register, floor at zero
          if (tick) begin
            if (ramp_level <= sd_ramp || sd_ramp == 16'h0000) begin
              ramp_level   <= 16'h0000;
              drive_enable <= 1'b0;
              sd_state     <= DSR_SD_OFF;
            end else begin
              ramp_level <= ramp_level - sd_ramp;
            end
          end
        end
        DSR_SD_OFF: begin
          // Restart only once cool; a hot restart would retrip anyway
          if (!s_temp) begin
            sd_state <= DSR_SD_IDLE;
          end
        end
        default: sd_state <= DSR_SD_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Lamps and interrupt
  // -----------------------------------------------------------------
  logic any_err;
  assign any_err = |live || diag[D_VALID];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_fault_lamp <= 1'b0;
      bus_fault_lamp   <= 1'b1;
      temp_lamp        <= 1'b0;
      ready_lamp       <= 1'b0;
      irq              <= 1'b0;
    end else begin
      group_fault_lamp <= any_err && !(s_cyc && !(|live));
      bus_fault_lamp   <= !s_cyc;
      temp_lamp        <= s_temp;
      ready_lamp       <= s_rdy;
      irq              <= |(status & mask);
    end
  end

  // -----------------------------------------------------------------
  // APB read path, zero wait states
  // -----------------------------------------------------------------
  always_comb begin
    pready  = 1'b1;
    pslverr = psel && penable && !is_mapped(paddr);
    prdata  = '0;
    if (rd_en) begin
      case (paddr)
        OFS_STATUS:  prdata = 32'(status);
        OFS_MASK:    prdata = 32'(mask);
        OFS_CTRL:    prdata = ctrl;
        OFS_LIVE:    prdata = {15'h0000, signalled, 4'h0, live};
        OFS_DIAG:    prdata = diag;
        OFS_SDDELAY: prdata = {16'h0000, sd_delay};
        OFS_SDRAMP:  prdata = {16'h0000, sd_ramp};
        default:     prdata = '0;
      endcase
    end
  end

endmodule

// ==== dsr_props.sv ====
// Checker for the diagnostic status reporter: lamp and shutdown timing.
// Assumes it is bound to dsr_top and sees only that module's ports.
`timescale 1ns/100ps

module dsr_props
  import dsr_pkg::*;
#(
  parameter int unsigned ENC_N = NUM_ENC
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                sync_lost,
  input wire logic                overtemp,
  input wire logic                drive_ready,
  input wire logic                ready_contact,
  input wire logic                cyclic_exchange,
  input wire logic [ENC_N*16-1:0] encoder_control_word,
  input wire logic [ENC_N-1:0]    enc_wire_break,
  input wire logic [ENC_N-1:0]    enc_zero_mark_err,
  input wire logic [ENC_N-1:0]    step_mismatch,
  input wire logic                group_fault_lamp,
  input wire logic                bus_fault_lamp,
  input wire logic                temp_lamp,
  input wire logic                ready_lamp,
  input wire logic                drive_enable
);
  logic cmd_any;
  logic fault_any;
  logic quiet;

  // Zero-mark pins left out of fault_any: their meaning hangs on mode bits
  always_comb begin
    cmd_any = 1'b0;
    for (int i = 0; i < ENC_N; i++) begin
      cmd_any = cmd_any | (|encoder_control_word[16*i+8 +: 5]);
    end
    fault_any = sync_lost | overtemp | !drive_ready | (|enc_wire_break)
                | cmd_any;
    quiet = !fault_any && !(|enc_zero_mark_err) && !(|step_mismatch);
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence hot_s;
    overtemp [*5];
  endsequence
  sequence cool_s;
    !overtemp [*5];
  endsequence
  sequence calm_link_s;
    (cyclic_exchange && quiet) [*5];
  endsequence

  temp_on_a: assert property (hot_s |-> temp_lamp)
    else $error("temp lamp dark while hot");
  temp_off_a: assert property (cool_s |-> !temp_lamp)
    else $error("temp lamp lit while cool");
  ready_follow_a: assert property ($stable(ready_contact) [*5] |->
    ready_lamp == ready_contact) else $error("ready lamp off contact");
  bus_follow_a: assert property ($stable(cyclic_exchange) [*5] |->
    bus_fault_lamp == !cyclic_exchange) else $error("bus lamp wrong");
  quiet_lamps_a: assert property (calm_link_s |->
    !group_fault_lamp && !bus_fault_lamp) else $error("lamps lit in exchange");
  group_on_a: assert property (fault_any [*5] |-> group_fault_lamp)
    else $error("group lamp dark with fault");
  cmd_fault_a: assert property (cmd_any [*5] |-> group_fault_lamp)
    else $error("bad command not shown");
  drive_off_a: assert property ($fell(drive_enable) |-> temp_lamp)
    else $error("drive cut without heat");
  drive_back_a: assert property (!overtemp [*8] |-> drive_enable)
    else $error("drive held off while cool");
endmodule

bind dsr_top dsr_props #(.ENC_N(ENC_N)) u_props (
  .pclk                 (pclk),
  .presetn              (presetn),
  .sync_lost            (sync_lost),
  .overtemp             (overtemp),
  .drive_ready          (drive_ready),
  .ready_contact        (ready_contact),
  .cyclic_exchange      (cyclic_exchange),
  .encoder_control_word (encoder_control_word),
  .enc_wire_break       (enc_wire_break),
  .enc_zero_mark_err    (enc_zero_mark_err),
  .step_mismatch        (step_mismatch),
  .group_fault_lamp     (group_fault_lamp),
  .bus_fault_lamp       (bus_fault_lamp),
  .temp_lamp            (temp_lamp),
  .ready_lamp           (ready_lamp),
  .drive_enable         (drive_enable)
);

// ==== dsr_master_model.sv ====
// Fieldbus master model: reads diagnostics and acknowledges blocks over APB.
// Assumes the slave shares pclk; waits on pready without a cycle count.
`timescale 1ns/100ps

module dsr_master_model
  import dsr_pkg::*;
(
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Frees the diag slot so the next held condition can be reported
  task automatic ack_diag();
    logic [31:0] q;
    logic        e;
    xfer(1'b1, OFS_ACK, 32'h0000_0001, q, e);
  endtask
endmodule

// ==== diagnostic_status_reporter_tb.sv ====
// Self-checking bench for dsr_top: lamps, shutdown, diag blocks, interrupt.
// Assumes dsr_master_model drives the APB side.
`timescale 1ns/100ps

module diagnostic_status_reporter_tb;
  import dsr_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        sync_lost, overtemp, drive_ready, ready_contact;
  logic        cyclic_exchange, irq, drive_enable;
  logic [15:0] ramp_level;
  logic        group_fault_lamp, bus_fault_lamp, temp_lamp, ready_lamp;
  logic [63:0] encoder_control_word;
  logic [3:0]  enc_wire_break, enc_zero_mark_err, step_mismatch;
  logic [3:0]  proximity_switch_signal;
  int          n_fail, samples_checked, cycles;

  dsr_master_model u_mst (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  dsr_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_lost(sync_lost), .overtemp(overtemp), .drive_ready(drive_ready),
    .ready_contact(ready_contact), .cyclic_exchange(cyclic_exchange),
    .encoder_control_word(encoder_control_word),
    .enc_wire_break(enc_wire_break), .enc_zero_mark_err(enc_zero_mark_err),
    .step_mismatch(step_mismatch),
    .proximity_switch_signal(proximity_switch_signal),
    .group_fault_lamp(group_fault_lamp), .bus_fault_lamp(bus_fault_lamp),
    .temp_lamp(temp_lamp), .ready_lamp(ready_lamp),
    .drive_enable(drive_enable), .ramp_level(ramp_level), .irq(irq));

  task automatic print_verdict();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    u_mst.xfer(1'b0, a, 32'h0, q, e);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    u_mst.xfer(1'b1, a, d, q, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  function automatic logic [31:0] blk(logic c, logic [7:0] s, logic [3:0] k);
    return {1'b1, 6'h00, c, s, CHAN_ALWAYS, 4'h0, k};
  endfunction

  // Polls for a valid block, then compares the fields under m
  task automatic diag_is(input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    q = 32'h0;
    for (int i = 0; i < 20 && q[D_VALID] !== 1'b1; i++) rd(OFS_DIAG, q);
    chk(q & m, exp & m);
  endtask

  task automatic t_irq();
    logic [31:0] q;
    logic        e;
    rd(OFS_MASK, q);
    chk(q, RST_MASK);
    u_mst.xfer(1'b0, 12'h020, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    wr(OFS_MASK, 32'h1 << B_SYNC);
    sync_lost <= 1'b1;
    cyc(3);
    sync_lost <= 1'b0;
    cyc(6);
    chk(32'({irq, group_fault_lamp}), 32'h3);
    rd(OFS_STATUS, q);
    chk(q, 32'h1 << B_SYNC);
    rd(OFS_STATUS, q);
    chk(q, 32'h0);
    chk(32'(irq), 32'h0);
    rd(OFS_LIVE, q);
    chk(q, 32'h0001_0000);
    diag_is(blk(CLASS_INT, SLOT_MODULE, CAUSE_SYNC), '1);
    u_mst.ack_diag();
    wr(OFS_MASK, 32'h0);
  endtask

  task automatic t_lamps();
    cyclic_exchange <= 1'b1;
    ready_contact <= 1'b1;
    cyc(6);
    chk(32'({group_fault_lamp, bus_fault_lamp, ready_lamp}), 32'h1);
    cyclic_exchange <= 1'b0;
    ready_contact <= 1'b0;
    cyc(6);
    chk(32'({bus_fault_lamp, ready_lamp}), 32'h2);
    cyclic_exchange <= 1'b1;
  endtask

  // Delay 3+1 ticks, one ramp tick, 25 cycles each: off by 130
  task automatic t_temp();
    wr(OFS_SDDELAY, 32'h3);
    wr(OFS_SDRAMP, 32'h0);
    overtemp <= 1'b1;
    cyc(60);
    chk(32'({temp_lamp, group_fault_lamp, irq, drive_enable}), 32'hd);
    chk(32'(ramp_level), 32'h0000_ffff);
    cyc(80);
    chk(32'(drive_enable), 32'h0);
    chk(32'(ramp_level), 32'h0);
    diag_is(blk(CLASS_INT, SLOT_MODULE, CAUSE_TEMP), '1);
    u_mst.ack_diag();
    overtemp <= 1'b0;
    cyc(12);
    chk(32'(drive_enable), 32'h1);
    chk(32'(ramp_level), 32'h0000_ffff);
    // No delay, half-scale step: one step down, then off
    wr(OFS_SDDELAY, 32'h0);
    wr(OFS_SDRAMP, 32'h8000);
    overtemp <= 1'b1;
    for (int i = 0; i < 100 && ramp_level === 16'hffff; i++) cyc(1);
    chk(32'(ramp_level), 32'h0000_7fff);
    cyc(40);
    chk(32'(drive_enable), 32'h0);
    overtemp <= 1'b0;
    cyc(12);
    chk(32'(drive_enable), 32'h1);
  endtask

  task automatic t_multi();
    logic [31:0] q;
    rd(OFS_STATUS, q);
    sync_lost <= 1'b1;
    enc_wire_break <= 4'h2;
    diag_is(blk(CLASS_INT, SLOT_MODULE, CAUSE_SYNC), '1);
    rd(OFS_STATUS, q);
    chk(q, 32'h21);
    diag_is(blk(CLASS_INT, SLOT_MODULE, CAUSE_SYNC), '1);
    u_mst.ack_diag();
    diag_is(blk(CLASS_EXT, SLOT_ENC0 + 8'h03, CAUSE_WIRE), '1);
    u_mst.ack_diag();
    sync_lost <= 1'b0;
    enc_wire_break <= 4'h0;
    cyc(6);
    rd(OFS_STATUS, q);
    for (int i = 0; i < 4; i++) begin
      enc_wire_break <= 4'(1 << i);
      diag_is(blk(CLASS_EXT, SLOT_ENC0 + 8'(3 * i), CAUSE_WIRE), '1);
      u_mst.ack_diag();
      enc_wire_break <= 4'h0;
      cyc(6);
    end
  endtask

  // Slot of a command fault is left open, so it is masked out
  task automatic t_cmd();
    logic [31:0] q;
    for (int b = 8; b <= 12; b++) begin
      encoder_control_word <= 64'h1 << (32 + b);
      diag_is(blk(CLASS_INT, 8'h00, CAUSE_CMD), 32'hff00_ff0f);
      u_mst.ack_diag();
      encoder_control_word <= '0;
      cyc(6);
      rd(OFS_STATUS, q);
    end
  endtask

  task automatic t_zmark();
    enc_zero_mark_err <= 4'h8;
    diag_is(blk(CLASS_EXT, SLOT_ENC0 + 8'h09, CAUSE_ZMARK), '1);
    u_mst.ack_diag();
    enc_zero_mark_err <= 4'h0;
    wr(OFS_CTRL, 32'h1 << (C_STEPPER + 1));
    step_mismatch <= 4'h2;
    proximity_switch_signal <= 4'h2;
    diag_is(blk(CLASS_EXT, SLOT_ENC0 + 8'h03, CAUSE_ZMARK), '1);
    u_mst.ack_diag();
    step_mismatch <= 4'h0;
    proximity_switch_signal <= 4'h0;
    drive_ready <= 1'b0;
    diag_is(blk(CLASS_EXT, SLOT_MODULE, CAUSE_DRDY), '1);
    u_mst.ack_diag();
    drive_ready <= 1'b1;
  endtask

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    presetn = 1'b0;
    {sync_lost, overtemp, ready_contact, cyclic_exchange} = 4'h0;
    drive_ready = 1'b1;
    encoder_control_word = '0;
    {enc_wire_break, enc_zero_mark_err} = 8'h00;
    {step_mismatch, proximity_switch_signal} = 8'h00;
    cyc(16);
    presetn <= 1'b1;
    t_irq();
    t_lamps();
    t_temp();
    t_multi();
    t_cmd();
    t_zmark();
    print_verdict();
  end
endmodule
